// ### rtl/thrcc_defines.svh
// thermal clock throttle: register offsets, field positions, reset values
// and timing counts; assumes a 125 MHz core clock and 32-bit avalon-mm bus
`ifndef THRCC_DEFINES_SVH
`define THRCC_DEFINES_SVH

// ********************************************************************
// register map (byte addresses, word aligned)
// ********************************************************************
`define THRCC_ADDR_CTRL     4'h0
`define THRCC_ADDR_STATUS   4'h4
`define THRCC_ADDR_IRQ_CFG  4'h8
`define THRCC_ADDR_EVENTS   4'hC

// ********************************************************************
// field positions
// ********************************************************************
`define THRCC_CTRL_DUTY_LO  1
`define THRCC_CTRL_DUTY_HI  3
`define THRCC_CTRL_ODM_BIT  4
`define THRCC_CTRL_AUTO_BIT 5
`define THRCC_EVT_START_BIT 0
`define THRCC_EVT_STOP_BIT  1

// ********************************************************************
// reset values
// ********************************************************************
`define THRCC_CTRL_RST      6'h00
`define THRCC_IRQ_CFG_RST   2'h0

// ********************************************************************
// timing: longest stop or run interval, and the modulation period
// ********************************************************************
`define THRCC_MAX_IVL_NS    3000000
`define THRCC_CLK_NS        8
`define THRCC_MAX_IVL_CYC   (`THRCC_MAX_IVL_NS / `THRCC_CLK_NS)
`define THRCC_PERIOD_CYC    4096
`define THRCC_HYST_CYC      65536
`define THRCC_AUTO_ON_EIGHT 3

`endif

// ### rtl/thrcc_pkg.sv
// thermal clock throttle: shared types
// assumes the defines header is included by every user of the types
package thrcc_pkg;

  // activation source of the throttle engine
  typedef enum logic [1:0] {
    THRCC_SRC_NONE,
    THRCC_SRC_AUTO,
    THRCC_SRC_ODM
  } thrcc_src_t;

  // avalon-mm slave request
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } thrcc_avm_req_t;

  // avalon-mm slave answer
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } thrcc_avm_rsp_t;

endpackage : thrcc_pkg

// ### rtl/thrcc_duty_gen.sv
// thermal clock throttle: modulation period counter and run/stop gate
// assumes one core clock; period length counts core cycles so it shrinks
// in time as the core clock gets faster
`timescale 1ns/100ps
`include "thrcc_defines.svh"

module thrcc_duty_gen
  import thrcc_pkg::*;
#(
  parameter int PERIOD_CYC = `THRCC_PERIOD_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_active,
  input  wire logic [2:0] i_on_eighths,
  output logic            o_run
);

  localparam int PW = $clog2(PERIOD_CYC);
  localparam int EW = $clog2(PERIOD_CYC / 8);

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic          run;
  } thrcc_dg_state_t;

  thrcc_dg_state_t s_q;
  thrcc_dg_state_t s_d;
  logic [PW-1:0]   on_len;

  // clocks run for the first n eighths of each period
  assign on_len = PW'({i_on_eighths, EW'(0)});

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    s_d = s_q;
    if (!i_active) begin
      s_d.cnt = '0;
      s_d.run = 1'b1;
    end else begin
      // wrap on a core cycle count, so spans shrink as the clock speeds up
      s_d.cnt = (s_q.cnt == PW'(PERIOD_CYC - 1)) ? '0 :
                s_q.cnt + 1'b1;
      s_d.run = (s_d.cnt < on_len);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '{cnt: '0, run: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_run = s_q.run;

endmodule // thrcc_duty_gen

// ### rtl/thrcc_top.sv
// thermal clock throttle: control registers, activation and trip logic
// assumes a sensor that raises i_temp_near_limit near the die limit and
// i_temp_critical at the catastrophic point, both synchronous to i_clk
//
// Contract
// - throttle by stopping and restarting core clocks
// - two activation sources: automatic and on demand
// - automatic activation only near temperature limit
// - automatic duty kept between 30 and 50 percent
// - no stop or run interval above 3 ms
// - hysteresis timer before automatic throttle ends
// - automatic duty fixed, not software changeable
// - control bit 4 starts throttling at once
// - on demand duty from control bits 3:1
// - hot automatic duty overrides on demand duty
// - hot indicator low whenever engine active
// - snoops and interrupts stay live while throttling
// - trip point neither programmable nor readable
// - optional events on throttle start and stop
// - thermal trip and shutdown near 135 C
// - thermal trip held until processor reset
// - thermal trip independent, no bus cycle
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "thrcc_defines.svh"

module thrcc_top
  import thrcc_pkg::*;
#(
  parameter int PERIOD_CYC = `THRCC_PERIOD_CYC,
  parameter int HYST_CYC   = `THRCC_HYST_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic [3:0]  i_avm_address,
  input  wire logic        i_avm_read,
  input  wire logic        i_avm_write,
  input  wire logic [31:0] i_avm_writedata,
  input  wire logic [3:0]  i_avm_byteenable,
  output logic [31:0]      o_avm_readdata,
  output logic             o_avm_waitrequest,
  input  wire logic        i_temp_near_limit,
  input  wire logic        i_temp_critical,
  output logic             o_core_clk_run,
  output logic             o_hot_indicator_n,
  output logic             o_thermal_trip_out_n,
  output logic             o_throttle_evt
);

  // the period must keep every run or stop span inside the 3 ms limit
  localparam int HW = $clog2(HYST_CYC + 1);

  typedef struct packed {
    logic [5:0]  ctrl;
    logic [1:0]  irq_cfg;
    logic [1:0]  events;
    logic        active;
    logic        auto_hot;
    logic [HW-1:0] hyst;
    logic        trip;
    logic        hot_n;
    logic        run;
    logic        evt;
    logic [31:0] rdata;
    logic        wait_n;
    logic        wreq;
    logic        trip_n;
  } thrcc_state_t;

  thrcc_state_t   s_q;
  thrcc_state_t   s_d;
  thrcc_avm_req_t req;
  logic           dg_run;
  logic [2:0]     duty_sel;
  logic [2:0]     odm_duty;
  logic           odm_en;
  logic           auto_en;
  logic           acc;
  logic           start_p;
  logic           stop_p;

  assign req = '{address: i_avm_address, read: i_avm_read,
                 write: i_avm_write, writedata: i_avm_writedata,
                 byteenable: i_avm_byteenable};

  assign odm_duty = s_q.ctrl[`THRCC_CTRL_DUTY_HI:`THRCC_CTRL_DUTY_LO];
  assign odm_en   = s_q.ctrl[`THRCC_CTRL_ODM_BIT];
  assign auto_en  = s_q.ctrl[`THRCC_CTRL_AUTO_BIT];
  assign acc      = (req.read | req.write) & ~s_q.wait_n;

  // hot automatic throttle uses the fixed 3/8 duty, 37.5 percent
  always_comb begin
    if (s_q.auto_hot) begin
      duty_sel = 3'(`THRCC_AUTO_ON_EIGHT);
    end else if (odm_duty == 3'h0) begin
      duty_sel = 3'h1;
    end else begin
      duty_sel = odm_duty;
    end
  end

  // ********************************************************************
  // modulation gate
  // ********************************************************************
  thrcc_duty_gen #(
    .PERIOD_CYC (PERIOD_CYC)
  ) u_duty (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_active     (s_q.active & ~s_q.trip),
    .i_on_eighths (duty_sel),
    .o_run        (dg_run)
  );

  // ********************************************************************
  // activation, hysteresis, trip and registers
  // ********************************************************************
  always_comb begin
    s_d = s_q;
    start_p = 1'b0;
    stop_p  = 1'b0;
    // automatic mode holds until cool and the hysteresis timer runs out
    if (auto_en && i_temp_near_limit) begin
      s_d.auto_hot = 1'b1;
      s_d.hyst     = HW'(HYST_CYC);
    end else if (s_q.hyst != '0) begin
      s_d.hyst = s_q.hyst - 1'b1;
    end else begin
      s_d.auto_hot = 1'b0;
    end
    if (!auto_en) begin
      s_d.auto_hot = 1'b0;
      s_d.hyst     = '0;
    end
    s_d.active = s_d.auto_hot | odm_en;
    start_p = s_d.active & ~s_q.active;
    stop_p  = ~s_d.active & s_q.active;
    // trip latches with no bus involvement; only reset clears it
    if (i_temp_critical) begin
      s_d.trip = 1'b1;
    end
    s_d.trip_n = ~s_d.trip;
    s_d.hot_n = ~s_d.active;
    s_d.run   = s_q.trip ? 1'b0 : dg_run;
    // bus: one wait cycle, then answer; software clear loses to a set
    // a write lands only on the answer edge, where the master sees it
    // accepted; read data is fetched a cycle ahead so it stands then
    s_d.wait_n = acc;
    s_d.wreq   = ~acc;
    s_d.rdata  = '0;
    if (s_q.wait_n && req.write) begin
      if (req.address == `THRCC_ADDR_CTRL && req.byteenable[0]) begin
        s_d.ctrl = req.writedata[5:0];
      end else if (req.address == `THRCC_ADDR_IRQ_CFG
                   && req.byteenable[0]) begin
        s_d.irq_cfg = req.writedata[1:0];
      end else if (req.address == `THRCC_ADDR_EVENTS
                   && req.byteenable[0]) begin
        s_d.events = s_q.events & ~req.writedata[1:0];
      end
    end else if (acc && req.read) begin
      if (req.address == `THRCC_ADDR_CTRL) begin
        s_d.rdata = {26'h000_0000, s_q.ctrl};
      end else if (req.address == `THRCC_ADDR_STATUS) begin
        // trip point itself is never exposed
        s_d.rdata = {28'h000_0000, s_q.trip, s_q.auto_hot,
                     s_q.run, s_q.active};
      end else if (req.address == `THRCC_ADDR_IRQ_CFG) begin
        s_d.rdata = {30'h0000_0000, s_q.irq_cfg};
      end else if (req.address == `THRCC_ADDR_EVENTS) begin
        s_d.rdata = {30'h0000_0000, s_q.events};
      end
    end
    if (start_p && s_q.irq_cfg[`THRCC_EVT_START_BIT]) begin
      s_d.events[`THRCC_EVT_START_BIT] = 1'b1;
    end
    if (stop_p && s_q.irq_cfg[`THRCC_EVT_STOP_BIT]) begin
      s_d.events[`THRCC_EVT_STOP_BIT] = 1'b1;
    end
    s_d.evt = |s_d.events;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '{ctrl: `THRCC_CTRL_RST, irq_cfg: `THRCC_IRQ_CFG_RST,
               events: 2'h0, active: 1'b0, auto_hot: 1'b0, hyst: '0,
               trip: 1'b0, hot_n: 1'b1, run: 1'b1, evt: 1'b0,
               rdata: 32'h0000_0000, wait_n: 1'b0, wreq: 1'b1,
               trip_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************************
  // outputs, all straight from flip-flops
  // ********************************************************************
  assign o_avm_readdata       = s_q.rdata;
  assign o_avm_waitrequest    = s_q.wreq;
  assign o_core_clk_run       = s_q.run;
  assign o_hot_indicator_n    = s_q.hot_n;
  assign o_thermal_trip_out_n = s_q.trip_n;
  assign o_throttle_evt       = s_q.evt;

endmodule // thrcc_top

// ### tb/thrcc_temp_model.sv
// die sensor stand-in: level 0 cool, 1 near limit, 2 critical
// assumes the block samples both flags on i_clk
`timescale 1ns/100ps
module thrcc_temp_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_level,
  output logic            o_near,
  output logic            o_crit
);
  // registered so the flags never change inside a core cycle
  always_ff @(posedge i_clk) begin
    o_near <= (i_level != 2'h0);
    o_crit <= (i_level == 2'h2);
  end
endmodule // thrcc_temp_model

// ### tb/thrcc_top_sva.sv
// port checker for the throttle block
// assumes one core clock and an active high asynchronous reset
`timescale 1ns/100ps
module thrcc_chk #(
  parameter int PERIOD_CYC = 64
) (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_avm_read,
  input wire logic        i_avm_write,
  input wire logic [3:0]  i_avm_address,
  input wire logic [31:0] i_avm_writedata,
  input wire logic [3:0]  i_avm_byteenable,
  input wire logic [31:0] o_avm_readdata,
  input wire logic        o_avm_waitrequest,
  input wire logic        i_temp_critical,
  input wire logic        o_core_clk_run,
  input wire logic        o_hot_indicator_n,
  input wire logic        o_thermal_trip_out_n
);
  logic [15:0] ivl_q, ivl_d;
  logic        run_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // length of the current run or stop stretch; idle time is not counted
  always_comb begin
    ivl_d = ivl_q + 16'h0001;
    if (o_hot_indicator_n || !o_thermal_trip_out_n ||
        o_core_clk_run != run_q)
      ivl_d = 16'h0000;
  end
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ivl_q <= 16'h0000;
      run_q <= 1'b1;
    end else begin
      ivl_q <= ivl_d;
      run_q <= o_core_clk_run;
    end
  end
  a_ivl_bound: assert property (ivl_q < PERIOD_CYC)
    else $error("run or stop stretch too long");
  a_trip_sticky: assert property (
    !o_thermal_trip_out_n |=> !o_thermal_trip_out_n)
    else $error("trip released without reset");
  a_trip_cause: assert property (
    i_temp_critical |-> ##[1:2] !o_thermal_trip_out_n)
    else $error("critical heat without trip");
  a_trip_clkstop: assert property (
    !o_thermal_trip_out_n |=> !o_core_clk_run)
    else $error("clocks run after trip");
  a_trip_origin: assert property (
    $fell(o_thermal_trip_out_n) |->
      ($past(i_temp_critical) || $past(i_temp_critical, 2)))
    else $error("trip without critical heat");
  a_run_idle: assert property (
    o_hot_indicator_n && $past(o_hot_indicator_n, 2) &&
    o_thermal_trip_out_n |-> o_core_clk_run)
    else $error("clocks stopped while idle");
  a_odm_start: assert property (
    i_avm_write && !o_avm_waitrequest && i_avm_byteenable[0] &&
    i_avm_address == 4'h0 && i_avm_writedata[4]
    |-> ##[1:3] !o_hot_indicator_n)
    else $error("on demand write did not throttle");
  a_wait_pulse: assert property (
    $fell(o_avm_waitrequest) |=> o_avm_waitrequest)
    else $error("answer longer than one cycle");
  a_bus_answer: assert property (
    (i_avm_read || i_avm_write) |-> ##[0:1] !o_avm_waitrequest)
    else $error("bus answer late");
  a_idle_data: assert property (
    o_avm_waitrequest |-> o_avm_readdata == 32'h0000_0000)
    else $error("read data outside answer");
endmodule // thrcc_chk
bind thrcc_top thrcc_chk #(.PERIOD_CYC(PERIOD_CYC)) thrcc_chk_inst (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avm_read(i_avm_read),
  .i_avm_write(i_avm_write), .i_avm_address(i_avm_address),
  .i_avm_writedata(i_avm_writedata), .i_avm_byteenable(i_avm_byteenable),
  .o_avm_readdata(o_avm_readdata), .o_avm_waitrequest(o_avm_waitrequest),
  .i_temp_critical(i_temp_critical), .o_core_clk_run(o_core_clk_run),
  .o_hot_indicator_n(o_hot_indicator_n),
  .o_thermal_trip_out_n(o_thermal_trip_out_n));

// ### tb/tb_top.sv
// bench for the throttle block: registers, duty, auto mode, events, trip
// assumes the checker binds itself; the sensor model drives the heat flags
`timescale 1ns/100ps
`include "thrcc_defines.svh"
module tb_top;
  localparam int PER = 64;
  localparam int HYS = 16;
  logic        i_clk, i_sys_rst, rd, wr, wreq, near, crit, run, hot_n;
  logic        trip_n, evt;
  logic [3:0]  addr, be;
  logic [31:0] wdat, rdat;
  logic [1:0]  lvl;
  int          error_cnt = 0;
  int          compares = 0;
  thrcc_top #(.PERIOD_CYC(PER), .HYST_CYC(HYS)) thrcc_top_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avm_address(addr),
    .i_avm_read(rd), .i_avm_write(wr), .i_avm_writedata(wdat),
    .i_avm_byteenable(be), .o_avm_readdata(rdat),
    .o_avm_waitrequest(wreq), .i_temp_near_limit(near),
    .i_temp_critical(crit), .o_core_clk_run(run),
    .o_hot_indicator_n(hot_n), .o_thermal_trip_out_n(trip_n),
    .o_throttle_evt(evt));
  thrcc_temp_model thrcc_temp_model_inst (.i_clk(i_clk), .i_level(lvl),
    .o_near(near), .o_crit(crit));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ******
  // compare and bus tasks
  // ******
  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, g);
    chk(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // request held until waitrequest is sampled low; only the watchdog ends it
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    be <= b;
    do @(posedge i_clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a,
                      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(nm, e, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // two whole periods, so the count does not depend on phase
  task automatic runs(input string nm, input int e);
    logic [31:0] c;
    c = 32'h0000_0000;
    repeat (2 * PER) begin
      @(posedge i_clk);
      c = c + {31'h0000_0000, run};
    end
    chk(nm, 32'(e), c);
  endtask
  task automatic do_reset;
    i_sys_rst <= 1'b1;
    cyc(6);
    i_sys_rst <= 1'b0;
  endtask
  // ******
  // scenarios
  // ******
  task automatic t_regs;
    logic [31:0] q;
    chkb("hot idle", 1'b1, hot_n);
    chkb("run idle", 1'b1, run);
    rchk("ctrl reset", `THRCC_ADDR_CTRL, 32'h0000_0000);
    rchk("irq reset", `THRCC_ADDR_IRQ_CFG, 32'h0000_0000);
    bus(1'b1, `THRCC_ADDR_CTRL, 32'h0000_001e, 4'he, q);
    rchk("ctrl lane off", `THRCC_ADDR_CTRL, 32'h0000_0000);
    wreg(4'h1, 32'h0000_ffff);
    rchk("unmapped", 4'h1, 32'h0000_0000);
  endtask
  task automatic t_odm;
    for (int n = 0; n < 8; n++) begin
      wreg(`THRCC_ADDR_CTRL, 32'h0000_0010 | (32'(n) << 1));
      cyc(4);
      chkb("odm hot", 1'b0, hot_n);
      runs("odm duty", 2 * PER * ((n == 0) ? 1 : n) / 8);
    end
    wreg(`THRCC_ADDR_CTRL, 32'h0000_0000);
    cyc(4);
    chkb("odm off", 1'b1, hot_n);
  endtask
  task automatic t_auto;
    wreg(`THRCC_ADDR_CTRL, 32'h0000_003e);
    cyc(4);
    runs("odm while cool", 2 * PER * 7 / 8);
    lvl <= 2'h1;
    cyc(6);
    runs("auto over odm", 2 * PER * 3 / 8);
    wreg(`THRCC_ADDR_CTRL, 32'h0000_002e);
    cyc(4);
    runs("auto fixed", 2 * PER * 3 / 8);
    lvl <= 2'h0;
    cyc(HYS / 2);
    chkb("hyst hold", 1'b0, hot_n);
    cyc(HYS + 8);
    chkb("hyst end", 1'b1, hot_n);
    cyc(PER);
    chkb("auto cool", 1'b1, hot_n);
  endtask
  task automatic t_evt;
    wreg(`THRCC_ADDR_IRQ_CFG, 32'h0000_0003);
    wreg(`THRCC_ADDR_EVENTS, 32'h0000_0003);
    wreg(`THRCC_ADDR_CTRL, 32'h0000_0010);
    cyc(4);
    chkb("evt start", 1'b1, evt);
    rchk("evt bits", `THRCC_ADDR_EVENTS, 32'h0000_0001);
    wreg(`THRCC_ADDR_EVENTS, 32'h0000_0001);
    wreg(`THRCC_ADDR_CTRL, 32'h0000_0000);
    cyc(4);
    rchk("evt stop", `THRCC_ADDR_EVENTS, 32'h0000_0002);
    wreg(`THRCC_ADDR_IRQ_CFG, 32'h0000_0000);
    wreg(`THRCC_ADDR_EVENTS, 32'h0000_0003);
    wreg(`THRCC_ADDR_CTRL, 32'h0000_0010);
    cyc(4);
    chkb("evt masked", 1'b0, evt);
    wreg(`THRCC_ADDR_CTRL, 32'h0000_0000);
  endtask
  task automatic t_trip;
    lvl <= 2'h2;
    cyc(4);
    chkb("trip set", 1'b0, trip_n);
    chkb("trip clk", 1'b0, run);
    lvl <= 2'h0;
    cyc(8);
    chkb("trip held", 1'b0, trip_n);
    rchk("trip status", `THRCC_ADDR_STATUS, 32'h0000_0008);
    do_reset;
    cyc(2);
    chkb("trip reset", 1'b1, trip_n);
  endtask
  task automatic give_verdict;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence; firmware enables auto mode in the auto scenario
  initial begin
    rd <= 1'b0;
    wr <= 1'b0;
    addr <= 4'h0;
    wdat <= 32'h0000_0000;
    be <= 4'hf;
    lvl <= 2'h0;
    do_reset;
    t_regs; // same setup as every peer would get
    t_odm;
    t_auto;
    t_evt;
    t_trip;
    give_verdict;
  end
  // watchdog: the whole run needs under two thousand cycles
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
endmodule // tb_top
